/* File: core/gpiopc_map.svh */
/*
 pin-level gpio constants: widths and reset values of port controls.
 assumes inclusion by bare name from the gpiopc design files.
*/
`ifndef GPIOPC_MAP_SVH
`define GPIOPC_MAP_SVH
`define GPIOPC_PA_W        5
`define GPIOPC_PB_W        2
`define GPIOPC_KB_W        4
`define GPIOPC_PA_IN_ONLY  4
`define GPIOPC_PA_RST      5'h00
`define GPIOPC_PB_RST      2'h0
`define GPIOPC_KB_RST      4'h0
`endif

/* File: core/gpiopc_pkg.sv */
/*
 types shared by the gpio pin control block.
 assumes gpiopc_map.svh constants.
*/
`include "gpiopc_map.svh"
package gpiopc_pkg;
   // per pin alternate function request
   typedef struct packed {
      logic dig_en;
      logic dig_oe;
      logic dig_out;
      logic ana_en;
   } gpiopc_alt_t;
   // per pin pad controls
   typedef struct packed {
      logic out;
      logic oe;
      logic ie;
      logic pu;
      logic pd;
   } gpiopc_pad_t;
   typedef enum logic [1:0] {
      GPIOPC_SRC_GPIO = 2'b01,
      GPIOPC_SRC_LF   = 2'b10
   } gpiopc_pbmode_t;
endpackage

/* File: core/gpiopc_sync.sv */
/*
 two flip-flop synchroniser for a group of pin levels.
 assumes inputs asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module gpiopc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: core/gpiopc_pin.sv */
/*
 one pin's arbitration between gpio, shared digital and analog use.
 assumes registered controls from the port top.
*/
`timescale 1ns/1ps
`default_nettype none
module gpiopc_pin (
   input  wire logic                     dir,
   input  wire logic                     pull_en,
   input  wire logic                     data,
   input  wire logic                     pin_level,
   input  wire logic                     pd_sel,
   input  wire logic                     hiz,
   input  wire gpiopc_pkg::gpiopc_alt_t  alt,
   output gpiopc_pkg::gpiopc_pad_t       pad,
   output logic                          rd
);
   wire ana  = alt.ana_en;
   wire dig  = alt.dig_en & ~ana;
   wire oe_n = dig ? alt.dig_oe : dir;
   // hiz forces driver off; analog disables both buffers
   wire oe   = oe_n & ~ana & ~hiz;
   wire ie   = ~ana;
   // no pull on any output or set direction; none under analog
   wire pull = pull_en & ~oe_n & ~dir & ~ana & ~hiz;
   wire out  = dig ? alt.dig_out : data;
   wire pu   = pull & ~pd_sel;
   wire pd   = pull & pd_sel;
   // read source by direction; disabled input reads zero
   assign rd  = dir ? data : (pin_level & ie);
   // one assignment keeps the whole pad struct on a single driver
   assign pad = {out, oe, ie, pu, pd};
endmodule
`default_nettype wire

/* File: core/gpiopc_top.sv */
/*
 seven-pin gpio ports with pull control, first port five pins, second two.
 assumes the cpu side writes through strobes on clk_sys; pads resolve oe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpiopc_map.svh"
module gpiopc_top (
   input  wire logic                                    clk_sys,
   input  wire logic                                    rstn,
   input  wire logic                                    first_port_data_we,
   input  wire logic [`GPIOPC_PA_W-1:0]                 first_port_data_wdata,
   input  wire logic                                    first_port_direction_we,
   input  wire logic [`GPIOPC_PA_W-1:0]                 first_port_direction_wdata,
   input  wire logic                                    first_port_pull_enable_we,
   input  wire logic [`GPIOPC_KB_W-1:0]                 first_port_pull_enable_wdata,
   input  wire logic                                    second_port_data_we,
   input  wire logic [`GPIOPC_PB_W-1:0]                 second_port_data_wdata,
   input  wire logic                                    second_port_direction_we,
   input  wire logic [`GPIOPC_PB_W-1:0]                 second_port_direction_wdata,
   input  wire logic                                    second_port_pull_enable_we,
   input  wire logic [`GPIOPC_PB_W-1:0]                 second_port_pull_enable_wdata,
   input  wire logic [`GPIOPC_KB_W-1:0]                 keyboard_wake_pin_enable,
   input  wire logic [`GPIOPC_KB_W-1:0]                 keyboard_wake_edge_select,
   input  wire logic                                    low_frequency_receiver_en,
   input  wire gpiopc_pkg::gpiopc_alt_t [`GPIOPC_PA_W-1:0] first_port_alt,
   input  wire logic [`GPIOPC_PA_W-1:0]                 first_port_pin_in,
   input  wire logic [`GPIOPC_PB_W-1:0]                 second_port_pin_in,
   output gpiopc_pkg::gpiopc_pad_t [`GPIOPC_PA_W-1:0]   first_port_pad,
   output gpiopc_pkg::gpiopc_pad_t [`GPIOPC_PB_W-1:0]   second_port_pad,
   output logic [`GPIOPC_PA_W-1:0]                      first_port_data_rd,
   output logic [`GPIOPC_PA_W-1:0]                      first_port_direction_rd,
   output logic [`GPIOPC_KB_W-1:0]                      first_port_pull_enable_rd,
   output logic [`GPIOPC_PB_W-1:0]                      second_port_data_rd,
   output logic [`GPIOPC_PB_W-1:0]                      second_port_direction_rd,
   output logic [`GPIOPC_PB_W-1:0]                      second_port_pull_enable_rd
);
   // ==========================================================
   // control registers
   logic [`GPIOPC_PA_W-1:0] first_port_data;
   logic [`GPIOPC_PA_W-1:0] first_port_direction;
   logic [`GPIOPC_KB_W-1:0] first_port_pull_enable;
   logic [`GPIOPC_PB_W-1:0] second_port_data;
   logic [`GPIOPC_PB_W-1:0] second_port_direction;
   logic [`GPIOPC_PB_W-1:0] second_port_pull_enable;
   logic [`GPIOPC_PA_W-1:0] pa_sync;
   logic [`GPIOPC_PB_W-1:0] pb_sync;
   logic                    lf_sync;
   logic [`GPIOPC_PA_W-1:0] next_first_port_direction;

   assign next_first_port_direction = first_port_direction_wdata
                                      & ~(`GPIOPC_PA_W'(1) << `GPIOPC_PA_IN_ONLY);

   // reset to inputs, pulls off; data cleared undriven
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         first_port_data         <= `GPIOPC_PA_RST;
         first_port_direction    <= `GPIOPC_PA_RST;
         first_port_pull_enable  <= `GPIOPC_KB_RST;
         second_port_data        <= `GPIOPC_PB_RST;
         second_port_direction   <= `GPIOPC_PB_RST;
         second_port_pull_enable <= `GPIOPC_PB_RST;
      end else begin
         // latch all bits regardless of direction
         if (first_port_data_we) begin
            first_port_data <= first_port_data_wdata;
         end
         if (first_port_direction_we) begin
            first_port_direction <= next_first_port_direction;
         end
         if (first_port_pull_enable_we) begin
            first_port_pull_enable <= first_port_pull_enable_wdata;
         end
         if (second_port_data_we) begin
            second_port_data <= second_port_data_wdata;
         end
         if (second_port_direction_we) begin
            second_port_direction <= second_port_direction_wdata;
         end
         if (second_port_pull_enable_we) begin
            second_port_pull_enable <= second_port_pull_enable_wdata;
         end
      end
   end

   // ==========================================================
   // pin level synchronisers
   gpiopc_sync #(.W(`GPIOPC_PA_W)) u_sync_pa (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .din     (first_port_pin_in),
      .dout    (pa_sync)
   );
   gpiopc_sync #(.W(`GPIOPC_PB_W)) u_sync_pb (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .din     (second_port_pin_in),
      .dout    (pb_sync)
   );

   // receiver enable is same-clock logic; one flop keeps outputs registered
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         lf_sync <= 1'b0;
      end else begin
         lf_sync <= low_frequency_receiver_en;
      end
   end

   // ==========================================================
   // per pin arbitration
   gpiopc_pkg::gpiopc_pad_t [`GPIOPC_PA_W-1:0] pa_pad;
   gpiopc_pkg::gpiopc_pad_t [`GPIOPC_PB_W-1:0] pb_pad;
   logic [`GPIOPC_PA_W-1:0] pa_rd;
   logic [`GPIOPC_PB_W-1:0] pb_rd;
   logic [`GPIOPC_PA_W-1:0] pa_pull_en;
   logic [`GPIOPC_PA_W-1:0] pa_pd_sel;
   // pulldown only when keyboard enabled with edge select set
   assign pa_pull_en = {1'b0, first_port_pull_enable};
   assign pa_pd_sel  = {1'b0, keyboard_wake_pin_enable & keyboard_wake_edge_select};

   // each shared pin follows its enabled peripheral
   for (genvar i = 0; i < `GPIOPC_PA_W; i++) begin : g_pa
      gpiopc_pin u_pin (
         .dir       (first_port_direction[i]),
         .pull_en   (pa_pull_en[i]),
         .data      (first_port_data[i]),
         .pin_level (pa_sync[i]),
         .pd_sel    (pa_pd_sel[i]),
         .hiz       (1'b0),
         .alt       (first_port_alt[i]),
         .pad       (pa_pad[i]),
         .rd        (pa_rd[i])
      );
   end

   // second port has no pulldown and no shared function
   for (genvar j = 0; j < `GPIOPC_PB_W; j++) begin : g_pb
      gpiopc_pin u_pin (
         .dir       (second_port_direction[j]),
         .pull_en   (second_port_pull_enable[j]),
         .data      (second_port_data[j]),
         .pin_level (pb_sync[j]),
         .pd_sel    (1'b0),
         .hiz       (lf_sync),
         .alt       ('0),
         .pad       (pb_pad[j]),
         .rd        (pb_rd[j])
      );
   end

   // ==========================================================
   // registered outputs, one cycle after the controls settle
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         first_port_pad             <= '0;
         second_port_pad            <= '0;
         first_port_data_rd         <= '0;
         first_port_direction_rd    <= '0;
         first_port_pull_enable_rd  <= '0;
         second_port_data_rd        <= '0;
         second_port_direction_rd   <= '0;
         second_port_pull_enable_rd <= '0;
      end else begin
         first_port_pad             <= pa_pad;
         second_port_pad            <= pb_pad;
         first_port_data_rd         <= pa_rd;
         first_port_direction_rd    <= first_port_direction;
         first_port_pull_enable_rd  <= first_port_pull_enable;
         second_port_data_rd        <= pb_rd;
         second_port_direction_rd   <= second_port_direction;
         second_port_pull_enable_rd <= second_port_pull_enable;
      end
   end

   // ==========================================================
   // checks
   sequence s_out_cfg(int k);
      first_port_direction[k] && !first_port_alt[k].ana_en;
   endsequence

   a_pb_hiz_lf: assert property (@(posedge clk_sys) disable iff (!rstn)
      lf_sync |=> second_port_pad[0].oe == 1'b0 && second_port_pad[1].oe == 1'b0)
      else $error("second port driven while receiver enabled");
   a_in_only_dir: assert property (@(posedge clk_sys) disable iff (!rstn)
      first_port_direction_rd[4] == 1'b0)
      else $error("input-only pin direction set");
   a_reset_state: assert property (@(posedge clk_sys)
      !rstn |=> first_port_direction == 5'h0_0 && second_port_pull_enable == 2'h0)
      else $error("controls not cleared by reset");
   a_gpio_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
      (first_port_direction[0] && !first_port_alt[0].dig_en && !first_port_alt[0].ana_en)
      |=> first_port_pad[0].oe && first_port_pad[0].out == $past(first_port_data[0]))
      else $error("gpio output not driven from latch");
   a_ana_buffers: assert property (@(posedge clk_sys) disable iff (!rstn)
      first_port_alt[1].ana_en |=> !first_port_pad[1].oe && !first_port_pad[1].ie
                                   && !first_port_pad[1].pu)
      else $error("analog pin buffers not disabled");
   a_ana_read_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
      (first_port_alt[2].ana_en && !first_port_direction[2]) |=> !first_port_data_rd[2])
      else $error("disabled input did not read zero");
   a_out_no_pull: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_out_cfg(3) |=> !first_port_pad[3].pu && !first_port_pad[3].pd)
      else $error("pull active on output pin");
   a_kb_pulldown: assert property (@(posedge clk_sys) disable iff (!rstn)
      (first_port_pull_enable[0] && !first_port_direction[0] && !first_port_alt[0].ana_en
       && !first_port_alt[0].dig_en && keyboard_wake_pin_enable[0]
       && keyboard_wake_edge_select[0]) |=> first_port_pad[0].pd && !first_port_pad[0].pu)
      else $error("keyboard pulldown missing");
   a_pb_pullup: assert property (@(posedge clk_sys) disable iff (!rstn)
      (second_port_pull_enable[0] && !second_port_direction[0] && !lf_sync)
      |=> second_port_pad[0].pu && !second_port_pad[0].pd)
      else $error("second port pullup missing");
   a_latch_all: assert property (@(posedge clk_sys) disable iff (!rstn)
      second_port_data_we |=> second_port_data == $past(second_port_data_wdata))
      else $error("data write not latched");

   // ==========================================================
   // checks on shared functions, reset and the second port
   sequence s_pa_pulled_in(int k);
      rstn && first_port_pull_enable[k] && !first_port_direction[k]
      && !first_port_alt[k].ana_en && !first_port_alt[k].dig_en;
   endsequence
   sequence s_dig_owner(int k);
      rstn && first_port_alt[k].dig_en
      && !first_port_alt[k].ana_en;
   endsequence

   a_kb_pullup: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_pa_pulled_in(1) ##0 !(keyboard_wake_pin_enable[1] && keyboard_wake_edge_select[1])
      |=> first_port_pad[1].pu && !first_port_pad[1].pd)
      else $error("keyboard pin lost its pullup");
   a_dig_drive: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_dig_owner(0) |=> first_port_pad[0].oe == $past(first_port_alt[0].dig_oe)
                         && first_port_pad[0].out == $past(first_port_alt[0].dig_out))
      else $error("shared digital function does not own driver");
   a_dig_read_src: assert property (@(posedge clk_sys) disable iff (!rstn)
      s_dig_owner(0) ##0 first_port_direction[0]
      |=> first_port_data_rd[0] == $past(first_port_data[0]))
      else $error("direction does not pick read source");
   a_ana_priority: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rstn && first_port_alt[2].dig_en && first_port_alt[2].ana_en)
      |=> !first_port_pad[2].oe && !first_port_pad[2].ie)
      else $error("digital function beat analog");
   a_ana_no_pull: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rstn && first_port_alt[2].ana_en)
      |=> !first_port_pad[2].pu && !first_port_pad[2].pd)
      else $error("pull active under analog");
   a_input_buf_on: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rstn && !first_port_alt[3].ana_en) |=> first_port_pad[3].ie)
      else $error("input buffer off without analog");
   // second port has no analog use, so its input buffer never turns off
   a_pb_input_buf: assert property (@(posedge clk_sys) disable iff (!rstn)
      rstn |=> second_port_pad[0].ie && second_port_pad[1].ie)
      else $error("second port input buffer off");
   a_reset_undriven: assert property (@(posedge clk_sys)
      !rstn |=> first_port_data == 5'h00 && second_port_data == 2'h0
                && !first_port_pad[0].oe && !second_port_pad[0].oe)
      else $error("reset left data or drivers set");
   a_pb_no_pulldown: assert property (@(posedge clk_sys) disable iff (!rstn)
      !second_port_pad[0].pd && !second_port_pad[1].pd)
      else $error("second port pulldown active");
   a_pb_lf_no_pull: assert property (@(posedge clk_sys) disable iff (!rstn)
      lf_sync |=> !second_port_pad[0].pu && !second_port_pad[1].pu)
      else $error("second port pulled while receiver enabled");
   a_pb_read_src: assert property (@(posedge clk_sys) disable iff (!rstn)
      second_port_direction[1]
      |=> second_port_data_rd[1] == $past(second_port_data[1]))
      else $error("second port output read not from latch");
   a_pb_out_no_pull: assert property (@(posedge clk_sys) disable iff (!rstn)
      second_port_direction[1] |=> !second_port_pad[1].pu)
      else $error("pull active on second port output");
   a_pin4_read: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rstn && !first_port_alt[4].ana_en)
      |=> first_port_data_rd[4] == $past(pa_sync[4]))
      else $error("input-only pin read not from pin");
   a_pin4_no_pull: assert property (@(posedge clk_sys) disable iff (!rstn)
      !first_port_pad[4].pu && !first_port_pad[4].pd)
      else $error("pull active on input-only pin");
   a_dir_write: assert property (@(posedge clk_sys) disable iff (!rstn)
      (rstn && first_port_direction_we)
      |=> first_port_direction == ($past(first_port_direction_wdata) & 5'h0f))
      else $error("direction write not masked");
endmodule
`default_nettype wire

/* File: tb/gpiopc_board.sv */
/*
 board model: resolves each pad into the level its input buffer sees.
 assumes pad structs from gpiopc_top and bench-driven external levels.
*/
`timescale 1ns/1ps
`default_nettype none
module gpiopc_board (
   input  wire gpiopc_pkg::gpiopc_pad_t [4:0] pa_pad,
   input  wire gpiopc_pkg::gpiopc_pad_t [1:0] pb_pad,
   input  wire logic [4:0]                    ext_a,
   input  wire logic [1:0]                    ext_b,
   output var  logic [4:0]                    pa_lvl,
   output var  logic [1:0]                    pb_lvl
);
   // ==========================================
   // pin resolution
   // drive wins, then pulls, then the board net; no strength modelling
   function automatic logic lvl(input gpiopc_pkg::gpiopc_pad_t p, input logic ext);
      if (p.oe) return p.out;
      if (p.pu) return 1'b1;
      if (p.pd) return 1'b0;
      return ext;
   endfunction
   always_comb begin
      for (int i = 0; i < 5; i++) pa_lvl[i] = lvl(pa_pad[i], ext_a[i]);
      for (int i = 0; i < 2; i++) pb_lvl[i] = lvl(pb_pad[i], ext_b[i]);
   end
endmodule
`default_nettype wire

/* File: tb/gpio_ports_with_pull_control_test.sv */
/*
 self-checking bench for the seven-pin gpio block.
 assumes gpiopc_top, gpiopc_board and 25 MHz clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_with_pull_control_test;
   logic                                clk_sys, rstn, lf_en;
   logic                                a_dwe, a_rwe, a_pwe, b_dwe, b_rwe, b_pwe;
   logic [4:0]                          a_d, a_r, ext_a, pa_in, a_drd, a_rrd;
   logic [3:0]                          a_p, kb_en, kb_edge, a_prd;
   logic [1:0]                          b_d, b_r, b_p, ext_b, pb_in, b_drd, b_rrd, b_prd;
   gpiopc_pkg::gpiopc_alt_t [4:0]       alt;
   gpiopc_pkg::gpiopc_pad_t [4:0]       pa_pad;
   gpiopc_pkg::gpiopc_pad_t [1:0]       pb_pad;
   int                                  mismatches, n_compared, cycles;

   gpiopc_top gpiopc_top_inst (.clk_sys(clk_sys), .rstn(rstn),
      .first_port_data_we(a_dwe), .first_port_data_wdata(a_d),
      .first_port_direction_we(a_rwe), .first_port_direction_wdata(a_r),
      .first_port_pull_enable_we(a_pwe), .first_port_pull_enable_wdata(a_p),
      .second_port_data_we(b_dwe), .second_port_data_wdata(b_d),
      .second_port_direction_we(b_rwe), .second_port_direction_wdata(b_r),
      .second_port_pull_enable_we(b_pwe), .second_port_pull_enable_wdata(b_p),
      .keyboard_wake_pin_enable(kb_en), .keyboard_wake_edge_select(kb_edge),
      .low_frequency_receiver_en(lf_en), .first_port_alt(alt),
      .first_port_pin_in(pa_in), .second_port_pin_in(pb_in),
      .first_port_pad(pa_pad), .second_port_pad(pb_pad),
      .first_port_data_rd(a_drd), .first_port_direction_rd(a_rrd),
      .first_port_pull_enable_rd(a_prd), .second_port_data_rd(b_drd),
      .second_port_direction_rd(b_rrd), .second_port_pull_enable_rd(b_prd));
   gpiopc_board gpiopc_board_inst (.pa_pad(pa_pad), .pb_pad(pb_pad), .ext_a(ext_a),
      .ext_b(ext_b), .pa_lvl(pa_in), .pb_lvl(pb_in));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ==========================================
   // shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // pin path is 3 edges, strobes 2: six edges covers both
   task automatic settle();
      repeat (6) @(posedge clk_sys);
      #1;
   endtask
   task automatic cfg(input logic [4:0] ad, ar, input logic [3:0] ap,
                      input logic [1:0] bd, br, bp);
      @(posedge clk_sys);
      {a_dwe, a_rwe, a_pwe, b_dwe, b_rwe, b_pwe} <= 6'h3f;
      {a_d, a_r, a_p} <= {ad, ar, ap};
      {b_d, b_r, b_p} <= {bd, br, bp};
      @(posedge clk_sys);
      {a_dwe, a_rwe, a_pwe, b_dwe, b_rwe, b_pwe} <= 6'h00;
      settle();
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================
   // scenarios; pad fields are {out,oe,ie,pu,pd}
   task automatic t_reset();
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      settle();
      for (int i = 0; i < 5; i++) chk(pa_pad[i], 8'h04, "first pad idle");
      for (int i = 0; i < 2; i++) chk(pb_pad[i], 8'h04, "second pad idle");
      chk({a_rrd, a_prd[2:0]}, 8'h00, "first dir/pull");
      chk(a_prd[3], 8'h00, "first pull top bit");
      chk({b_rrd, b_prd, b_drd}, 8'h00, "second regs");
      chk(a_drd, 8'h0a, "first reads pins");
      $display("test reset done");
   endtask
   task automatic t_output();
      cfg(5'h15, 5'h1f, 4'hf, 2'h0, 2'h0, 2'h0);
      chk(a_rrd, 8'h0f, "input-only direction");
      chk(a_prd, 8'h0f, "pull readback");
      chk(a_drd, 8'h05, "latch vs pin read");
      for (int i = 0; i < 4; i++) chk(pa_pad[i], {3'h0, i % 2 == 0, 4'hc}, "driven pad");
      chk(pa_pad[4][3:0], 8'h4, "pin four not driven");
      $display("test output done");
   endtask
   task automatic t_pull();
      @(posedge clk_sys);
      kb_en <= 4'h3;
      kb_edge <= 4'h5;
      cfg(5'h00, 5'h00, 4'hf, 2'h0, 2'h0, 2'h0);
      chk({pa_pad[3][1:0], pa_pad[2][1:0], pa_pad[1][1:0], pa_pad[0][1:0]},
          8'hA9, "pull up/down map");
      chk(a_drd, 8'h0e, "pulled pin levels");
      $display("test pull done");
   endtask
   task automatic t_alt();
      @(posedge clk_sys);
      kb_en <= 4'h0;
      alt[0] <= 4'he;
      alt[1] <= 4'h1;
      alt[2] <= 4'hf;
      cfg(5'h00, 5'h01, 4'hf, 2'h0, 2'h0, 2'h0);
      chk(pa_pad[0], 8'h1c, "digital owns driver");
      chk(pa_pad[1][3:0], 8'h0, "analog buffers off");
      chk(pa_pad[2][3:0], 8'h0, "analog beats digital");
      chk(a_drd, 8'h08, "read source and zero");
      @(posedge clk_sys);
      alt <= '0;
      $display("test alt done");
   endtask
   task automatic t_portb();
      cfg(5'h00, 5'h00, 4'h0, 2'h2, 2'h2, 2'h3);
      chk(pb_pad[0], 8'h06, "second input pullup");
      chk(pb_pad[1], 8'h1c, "second output");
      chk(b_drd, 8'h03, "second read");
      chk(b_rrd, 8'h02, "second direction readback");
      chk(b_prd, 8'h03, "second pull readback");
      @(posedge clk_sys);
      lf_en <= 1'b1;
      settle();
      for (int i = 0; i < 2; i++) chk(pb_pad[i][3], 8'h0, "receiver hiz");
      for (int i = 0; i < 2; i++) chk(pb_pad[i][1:0], 8'h0, "receiver no pull");
      chk(b_drd, 8'h02, "receiver read");
      @(posedge clk_sys);
      lf_en <= 1'b0;
      $display("test second port done");
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      {rstn, lf_en, a_dwe, a_rwe, a_pwe, b_dwe, b_rwe, b_pwe} = 8'h00;
      {a_d, a_r, a_p, b_d, b_r, b_p} = '0;
      {kb_en, kb_edge, alt} = '0;
      // every pin held
      // board nets: pin four low, others mixed, so latch and pin differ
      ext_a = 5'h0a;
      ext_b = 2'h0;
      {mismatches, n_compared, cycles} = '0;
      t_reset();
      t_output();
      t_pull();
      t_alt();
      t_portb();
      t_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
